// ===== design/blink_timebase.sv
// Blink phase generator: a counter toggles the phase every HALF_CYCLES clocks while running.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_pattern_icon_ram_defines.svh"

module blink_timebase #(
    parameter int unsigned HALF_CYCLES = 6660000
) (
    input  wire logic mclk_in,   // Core clock.
    input  wire logic rst_in,    // Asynchronous reset, active high.
    input  wire logic run_in,    // Oscillator running; blinking halts otherwise.
    output logic      phase_out  // High during the blank half of a blink period.
);

    typedef struct packed {
        logic [`BLINK_CNT_W-1:0] count;
        logic                    phase;
    } tb_s;

    localparam logic [`BLINK_CNT_W-1:0] LAST = `BLINK_CNT_W'(HALF_CYCLES - 1);

    tb_s s;
    tb_s next_s;

    // A half period of 333 ms gives a 1.5 Hz blink, centred in the 1 to 2 Hz band.
    always_comb begin
        next_s = s;
        if (run_in) begin
            if (s.count >= LAST) begin
                next_s.count = '0;
                next_s.phase = ~s.phase;
            end else begin
                next_s.count = s.count + `BLINK_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign phase_out = s.phase;

endmodule : blink_timebase

`default_nettype wire

// ===== design/lcd_pattern_icon_ram.sv
// Pattern, symbol, static icon and contrast memories behind the command/data port.
//
// Functional notes
// - User glyphs show only once system set enables pattern RAM; 240 bits, six glyphs.
// - Bank 1 codes 00H-05H use eight rows each at 00H-2FH; D4..D0 dots.
// - Eighth glyph row shows normally, inverted while the underline cursor is active.
// - 160-bit symbol memory, one bit per individually displayed symbol.
// - Symbol D7 enables blink; D6 picks inverted blink or set-bits blink; 1-2 Hz.
// - Ten static icons keep driving in standby; on bits at bank 0 00H, 01H.
// - Per-icon blink enables at bank 0 02H (A..E) and 03H (F..J).
// - Five-bit contrast value selects one of 32 drive voltage levels.
// - Address set: command with D7 high loads 7-bit address from D6..D0.
// - Data write stores at address, then address increments, wrapping 7FH to 00H.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_pattern_icon_ram_defines.svh"

module lcd_pattern_icon_ram
    import lcd_pattern_icon_ram_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_MS * `MCLK_KHZ
) (
    input  wire logic                    mclk_in,                // Core clock, 20 MHz.
    input  wire logic                    rst_in,                 // Async reset, active high.
    input  wire logic                    chip_select_n_in,       // Port select pin, active low.
    input  wire logic                    write_n_in,             // Write strobe pin, active low.
    input  wire logic                    command_data_select_in, // 0 command, 1 data.
    input  wire logic [7:0]              data_in,                // Data bus pins.
    input  wire logic                    underline_cursor_in,    // Underline cursor active.
    input  wire logic [2:0]              pattern_code_in,        // Glyph code being scanned.
    input  wire logic [2:0]              pattern_line_in,        // Glyph dot row being scanned.
    input  wire logic [4:0]              symbol_index_in,        // Symbol byte being scanned.
    output logic [4:0]                   pattern_row_out,        // Dots of the scanned glyph row.
    output logic                         pattern_active_out,     // Scanned code is a user glyph.
    output logic [4:0]                   symbol_row_out,         // Symbol dots after blinking.
    output logic [`ICON_COUNT-1:0]       static_icon_out,        // Icon drive, bit 9 is A.
    output logic [`VOLUME_W-1:0]         lcd_drive_voltage_out,  // Contrast step 0 to 31.
    output logic                         bank_select_bit_out,    // Current bank.
    output logic                         oscillator_on_out       // Oscillator running.
);
    import lcd_pattern_icon_ram_pkg::*;

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    logic [10:0] pins_sync;
    logic        cs_n_s;
    logic        wr_n_s;
    logic        cd_s;
    logic [7:0]  data_s;

    // Strobe and select idle high, so they reset high to avoid a false write.
    pin_sync #(
        .WIDTH   (11),
        .RST_VAL (11'h600)
    ) u_pin_sync (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .pins_in  ({chip_select_n_in, write_n_in, command_data_select_in, data_in}),
        .sync_out (pins_sync)
    );

    assign cs_n_s = pins_sync[10];
    assign wr_n_s = pins_sync[9];
    assign cd_s   = pins_sync[8];
    assign data_s = pins_sync[7:0];

    // ****************************************************************
    // Blink timebase
    // ****************************************************************
    ram_state_s s;
    ram_state_s next_s;
    logic       blink_phase;

    // The timebase stands in for the internal oscillator: it halts in sleep.
    blink_timebase #(
        .HALF_CYCLES (BLINK_HALF_CYCLES)
    ) u_blink_timebase (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .run_in    (s.osc_on),
        .phase_out (blink_phase)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic dots_t blink_dots(input dots_t bits,
                                         input logic  flag,
                                         input logic  style,
                                         input logic  phase);
        dots_t dots;
        dots = bits;
        if (flag && phase) begin
            if (style) begin
                dots = '0;
            end else begin
                dots = ~bits;
            end
        end
        return dots;
    endfunction : blink_dots

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic                        write_event;
    logic [5:0]                  pattern_index;
    logic [`SYMBOL_ENTRY_W-1:0]  symbol_entry;
    dots_t                       glyph_row;

    always_comb begin
        next_s        = s;
        write_event   = 1'b0;
        pattern_index = {pattern_code_in, pattern_line_in};
        symbol_entry  = s.symbol[symbol_index_in];
        glyph_row     = '0;

        // Bus levels are captured while the strobe is low, because the data hold
        // time after the rising strobe is shorter than the synchroniser delay.
        if (!wr_n_s) begin
            next_s.cap_data = data_s;
            next_s.cap_cd   = cd_s;
            next_s.cap_cs_n = cs_n_s;
        end
        next_s.wr_prev = wr_n_s;
        write_event    = wr_n_s && !s.wr_prev && !s.cap_cs_n;

        if (write_event) begin
            if (!s.cap_cd) begin
                if (s.cap_data[`BIT_ADDR_SET]) begin
                    next_s.address = s.cap_data[`ADDR_W-1:0];
                end else if (s.cap_data[`CMD_OP_HI:`CMD_OP_LO] == `CMD_BANK_SET) begin
                    next_s.bank_select_bit = s.cap_data[`BIT_BANK];
                end else if (s.cap_data[`CMD_OP_HI:`CMD_OP_LO] == `CMD_SYSTEM_SET) begin
                    next_s.pattern_ram_use = s.cap_data[`BIT_PATTERN_USE];
                    next_s.osc_on          = s.cap_data[`BIT_OSC_ON];
                end
            end else begin
                if (s.bank_select_bit) begin
                    if (s.address < `ADDR_PATTERN_END) begin
                        // Only the five dot bits are kept; D7..D5 are dropped.
                        next_s.pattern[s.address[5:0]] = s.cap_data[`DOT_W-1:0];
                    end else if (s.address >= `ADDR_SYMBOL_BASE) begin
                        next_s.symbol[s.address[4:0]] = {s.cap_data[7:6],
                                                         s.cap_data[`DOT_W-1:0]};
                    end
                end else begin
                    if (s.address == `ADDR_ICON_ON_A_E) begin
                        next_s.icon_on[9:5] = s.cap_data[4:0];
                    end else if (s.address == `ADDR_ICON_ON_F_J) begin
                        next_s.icon_on[4:0] = s.cap_data[4:0];
                    end else if (s.address == `ADDR_ICON_BLINK_A_E) begin
                        next_s.icon_blink[9:5] = s.cap_data[4:0];
                    end else if (s.address == `ADDR_ICON_BLINK_F_J) begin
                        next_s.icon_blink[4:0] = s.cap_data[4:0];
                    end else if (s.address == `ADDR_VOLUME) begin
                        next_s.contrast_volume_memory = s.cap_data[`VOLUME_W-1:0];
                    end
                end
                // The bank bit is untouched by data writes.
                next_s.address = s.address + `ADDR_W'(1);
            end
        end

        // ****************************************************************
        // Display read paths
        // ****************************************************************
        if (pattern_code_in < `GLYPH_COUNT) begin
            glyph_row = s.pattern[pattern_index];
        end
        if (underline_cursor_in && (pattern_line_in == `LAST_ROW)) begin
            glyph_row = ~glyph_row;
        end
        next_s.pattern_active = s.pattern_ram_use && (pattern_code_in < `GLYPH_COUNT);
        next_s.pattern_row    = next_s.pattern_active ? glyph_row : '0;

        next_s.symbol_row = blink_dots(symbol_entry[`DOT_W-1:0],
                                       symbol_entry[`DOT_W+1],
                                       symbol_entry[`DOT_W],
                                       blink_phase);

        // Icons keep their drive in standby; only the oscillator stops blinking.
        next_s.icon_drive = s.icon_on & ~(s.icon_blink & {`ICON_COUNT{blink_phase}});
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Memories clear on reset so a reset never leaves stray icons lit.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s          <= '0;
            s.wr_prev  <= 1'b1;
            s.cap_cs_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign pattern_row_out       = s.pattern_row;
    assign pattern_active_out    = s.pattern_active;
    assign symbol_row_out        = s.symbol_row;
    assign static_icon_out       = s.icon_drive;
    assign lcd_drive_voltage_out = s.contrast_volume_memory;
    assign bank_select_bit_out   = s.bank_select_bit;
    assign oscillator_on_out     = s.osc_on;

endmodule : lcd_pattern_icon_ram

`default_nettype wire

// ===== design/lcd_pattern_icon_ram_defines.svh
// Address map, command codes, field positions and timing figures of the display memory block.
`ifndef LCD_PATTERN_ICON_RAM_DEFINES_SVH
`define LCD_PATTERN_ICON_RAM_DEFINES_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define ADDR_W              7
`define DOT_W               5
`define VOLUME_W            5
`define ICON_COUNT          10
`define PATTERN_WORDS       48
`define SYMBOL_WORDS        32
`define SYMBOL_ENTRY_W      7
`define GLYPH_COUNT         3'h6
`define BLINK_CNT_W         23

// ****************************************************************
// Address map, bank 0
// ****************************************************************
`define ADDR_ICON_ON_A_E    7'h00
`define ADDR_ICON_ON_F_J    7'h01
`define ADDR_ICON_BLINK_A_E 7'h02
`define ADDR_ICON_BLINK_F_J 7'h03
`define ADDR_VOLUME         7'h08

// ****************************************************************
// Address map, bank 1
// ****************************************************************
`define ADDR_PATTERN_END    7'h30
`define ADDR_SYMBOL_BASE    7'h60
`define LAST_ROW            3'h7

// ****************************************************************
// Command and symbol data byte fields
// ****************************************************************
`define BIT_ADDR_SET        7
`define CMD_OP_HI           7
`define CMD_OP_LO           4
`define CMD_BANK_SET        4'h2
`define CMD_SYSTEM_SET      4'h3
`define BIT_BANK            0
`define BIT_PATTERN_USE     0
`define BIT_OSC_ON          1
`define BIT_BLINK_FLAG      7
`define BIT_BLINK_STYLE     6

// ****************************************************************
// Timing
// ****************************************************************
`define MCLK_KHZ            20000
`define BLINK_HALF_MS       333

`endif

// ===== design/lcd_pattern_icon_ram_pkg.sv
// Types shared by the display memory block.
`default_nettype none
`include "lcd_pattern_icon_ram_defines.svh"

package lcd_pattern_icon_ram_pkg;

    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DOT_W-1:0]  dots_t;

    typedef struct packed {
        logic                                          bank_select_bit;
        addr_t                                         address;
        logic                                          pattern_ram_use;
        logic                                          osc_on;
        logic                                          wr_prev;
        logic [7:0]                                    cap_data;
        logic                                          cap_cd;
        logic                                          cap_cs_n;
        logic [`PATTERN_WORDS-1:0][`DOT_W-1:0]         pattern;
        logic [`SYMBOL_WORDS-1:0][`SYMBOL_ENTRY_W-1:0] symbol;
        logic [`ICON_COUNT-1:0]                        icon_on;
        logic [`ICON_COUNT-1:0]                        icon_blink;
        logic [`VOLUME_W-1:0]                          contrast_volume_memory;
        dots_t                                         pattern_row;
        logic                                          pattern_active;
        dots_t                                         symbol_row;
        logic [`ICON_COUNT-1:0]                        icon_drive;
    } ram_state_s;

endpackage : lcd_pattern_icon_ram_pkg

`default_nettype wire

// ===== design/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int unsigned         WIDTH   = 1,
    parameter logic [WIDTH-1:0]    RST_VAL = '0
) (
    input  wire logic              mclk_in,   // Core clock.
    input  wire logic              rst_in,    // Asynchronous reset, active high.
    input  wire logic [WIDTH-1:0]  pins_in,   // Raw pin levels.
    output logic      [WIDTH-1:0]  sync_out   // Levels after two flip-flops.
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s s;
    sync_s next_s;

    // The first stage feeds only the second stage.
    always_comb begin
        next_s.first  = pins_in;
        next_s.second = s.first;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= {RST_VAL, RST_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.second;

endmodule : pin_sync

`default_nettype wire

// ===== verif/lcd_host_model.sv
// Host processor model that writes commands and data through the write port.
`timescale 1ns/100ps
`default_nettype none

module lcd_host_model (
    input  wire logic       mclk_in,                 // Clock.
    output logic            chip_select_n_out,       // Select, low.
    output logic            write_n_out,             // Strobe, low.
    output logic            command_data_select_out, // 0 command.
    output logic [7:0]      data_out                 // Bus.
);
    initial begin
        chip_select_n_out = 1'b1;
        write_n_out = 1'b1;
        command_data_select_out = 1'b0;
        data_out = 8'h00;
    end
    // Strobe low three cycles so the two-flop sync sees it, bus held one cycle past the rise.
    task automatic put(input logic cd, input logic [7:0] value);
        @(posedge mclk_in);
        chip_select_n_out <= 1'b0;
        command_data_select_out <= cd;
        data_out <= value;
        write_n_out <= 1'b0;
        repeat (3) @(posedge mclk_in);
        write_n_out <= 1'b1;
        @(posedge mclk_in);
        chip_select_n_out <= 1'b1;
        // A released bus must not look like it still holds the byte.
        data_out <= ~value;
        command_data_select_out <= ~cd;
        repeat (5) @(posedge mclk_in);
    endtask : put
endmodule : lcd_host_model
`default_nettype wire

// ===== verif/lcd_pattern_icon_ram_monitor.sv
// Port checker for the display memory block.
`timescale 1ns/100ps
`default_nettype none

module lcd_pattern_icon_ram_monitor (
    input wire logic       mclk_in,               // Clock.
    input wire logic       rst_in,                // Reset.
    input wire logic       write_n_in,            // Strobe.
    input wire logic [2:0] pattern_code_in,       // Glyph code.
    input wire logic [4:0] symbol_index_in,       // Symbol byte.
    input wire logic [4:0] pattern_row_out,       // Glyph dots.
    input wire logic       pattern_active_out,    // User glyph.
    input wire logic [4:0] symbol_row_out,        // Symbol dots.
    input wire logic [9:0] static_icon_out,       // Icons.
    input wire logic [4:0] lcd_drive_voltage_out, // Contrast.
    input wire logic       bank_select_bit_out,   // Bank.
    input wire logic       oscillator_on_out      // Oscillator.
);
    // ********
    // Checks
    // ********
    // Cycles since the strobe was low; stored values may move only shortly after a write.
    logic [3:0] since_low;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            since_low <= 4'hf;
        end else if (!write_n_in) begin
            since_low <= 4'h0;
        end else if (since_low != 4'hf) begin
            since_low <= since_low + 4'h1;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    property p_reset_clear;
        $fell(rst_in) |-> static_icon_out == 10'h000 && lcd_drive_voltage_out == 5'h00
            && !bank_select_bit_out && !oscillator_on_out;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not clear after reset");
    property p_volume_by_write;
        !$stable(lcd_drive_voltage_out) |-> since_low <= 4'h8;
    endproperty
    a_volume_by_write: assert property (p_volume_by_write)
        else $error("contrast moved without a write");
    property p_bank_by_write;
        $changed(bank_select_bit_out) |-> since_low inside {[4'h0:4'h8]};
    endproperty
    a_bank_by_write: assert property (p_bank_by_write)
        else $error("bank moved without a write");
    property p_osc_by_write;
        oscillator_on_out != $past(oscillator_on_out) |-> since_low < 4'h9;
    endproperty
    a_osc_by_write: assert property (p_osc_by_write)
        else $error("oscillator moved without a write");
    property p_code_range;
        pattern_active_out |-> $past(pattern_code_in) <= 3'h5;
    endproperty
    a_code_range: assert property (p_code_range)
        else $error("user glyph flagged for code above five");
    property p_row_needs_active;
        pattern_row_out != 5'h00 |-> pattern_active_out;
    endproperty
    a_row_needs_active: assert property (p_row_needs_active)
        else $error("glyph dots without user glyph");
    property p_icon_frozen;
        !oscillator_on_out && since_low == 4'hf |=> $stable(static_icon_out);
    endproperty
    a_icon_frozen: assert property (p_icon_frozen)
        else $error("icons moved with oscillator off");
    property p_symbol_frozen;
        !oscillator_on_out && since_low == 4'hf && $stable(symbol_index_in)
            |=> $stable(symbol_row_out);
    endproperty
    a_symbol_frozen: assert property (p_symbol_frozen)
        else $error("symbol moved with oscillator off");
    c_osc_on: cover property ($rose(oscillator_on_out));
    c_glyph: cover property (pattern_active_out && pattern_row_out != 5'h00);
    c_blink: cover property (since_low == 4'hf && $changed(static_icon_out));
endmodule : lcd_pattern_icon_ram_monitor
`default_nettype wire

// ===== verif/lcd_pattern_icon_ram_test.sv
// Self-checking bench for the display memory block.
`timescale 1ns/100ps
`default_nettype none

module lcd_pattern_icon_ram_test;
    // Short blink half period keeps the run brief.
    localparam int unsigned HALF = 8;
    logic       mclk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       chip_select_n_in;
    logic       write_n_in;
    logic       command_data_select_in;
    logic [7:0] data_in;
    logic       underline_cursor_in = 1'b0;
    logic [2:0] pattern_code_in = 3'h0;
    logic [2:0] pattern_line_in = 3'h0;
    logic [4:0] symbol_index_in = 5'h00;
    logic [4:0] pattern_row_out;
    logic       pattern_active_out;
    logic [4:0] symbol_row_out;
    logic [9:0] static_icon_out;
    logic [4:0] lcd_drive_voltage_out;
    logic       bank_select_bit_out;
    logic       oscillator_on_out;
    logic [7:0] vols [3] = '{8'he0, 8'hff, 8'h0a};
    int         miscompares = 0;
    int         check_count = 0;
    int         i;

    always #25 mclk_in = ~mclk_in;

    lcd_pattern_icon_ram #(.BLINK_HALF_CYCLES(HALF)) u_lcd_pattern_icon_ram (.mclk_in, .rst_in,
        .chip_select_n_in, .write_n_in, .command_data_select_in, .data_in, .underline_cursor_in,
        .pattern_code_in, .pattern_line_in, .symbol_index_in, .pattern_row_out,
        .pattern_active_out, .symbol_row_out, .static_icon_out, .lcd_drive_voltage_out,
        .bank_select_bit_out, .oscillator_on_out);
    lcd_host_model u_lcd_host_model (.mclk_in, .chip_select_n_out(chip_select_n_in),
        .write_n_out(write_n_in), .command_data_select_out(command_data_select_in),
        .data_out(data_in));

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic put(input logic cd, input logic [7:0] v);
        u_lcd_host_model.put(cd, v);
    endtask : put
    task automatic glyph(input logic [2:0] c, input logic [2:0] l, input logic u,
                         input logic [4:0] s);
        @(posedge mclk_in);
        pattern_code_in <= c;
        pattern_line_in <= l;
        underline_cursor_in <= u;
        symbol_index_in <= s;
        repeat (2) @(negedge mclk_in);
    endtask : glyph
    // Every sample must be one of two blink states, and both must appear.
    task automatic watch(input logic sym, input logic [9:0] a, input logic [9:0] b);
        logic [9:0] v;
        int         na;
        int         nb;
        na = 0;
        nb = 0;
        repeat (48) begin
            @(negedge mclk_in);
            v = sym ? {5'h00, symbol_row_out} : static_icon_out;
            if (v === a) na++;
            else if (v === b) nb++;
            else check(17'(v), 17'(a));
        end
        check(17'(na > 0 && nb > 0), 17'h1);
    endtask : watch
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge mclk_in);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(negedge mclk_in);
        check({oscillator_on_out, bank_select_bit_out, lcd_drive_voltage_out, static_icon_out}, 17'h0);
        put(1'b0, 8'h33);
        check(17'(oscillator_on_out), 17'h1);
        for (i = 0; i < 3; i++) begin
            put(1'b0, 8'h88);
            put(1'b1, vols[i]);
            check(17'(lcd_drive_voltage_out), 17'(vols[i][4:0]));
        end
        put(1'b0, 8'h88);
        put(1'b0, 8'h00);
        put(1'b0, 8'h40);
        put(1'b1, 8'h07);
        check(17'(lcd_drive_voltage_out), 17'h7);
        put(1'b0, 8'h80);
        put(1'b1, 8'hff);
        put(1'b1, 8'h0a);
        put(1'b1, 8'h01);
        put(1'b1, 8'h08);
        watch(1'b0, 10'h3ea, 10'h3c2);
        put(1'b0, 8'h82);
        put(1'b1, 8'h00);
        put(1'b1, 8'h00);
        repeat (3) begin
            repeat (6) @(negedge mclk_in);
            check(17'(static_icon_out), 17'h3ea);
        end
        put(1'b0, 8'h21);
        check(17'(bank_select_bit_out), 17'h1);
        put(1'b0, 8'ha8);
        for (i = 0; i < 8; i++) put(1'b1, {3'b111, 5'(i * 7 + 3)});
        for (i = 0; i < 8; i++) begin
            glyph(3'h5, 3'(i), 1'b0, 5'h1f);
            check(17'({pattern_active_out, pattern_row_out}), 17'({1'b1, 5'(i * 7 + 3)}));
        end
        glyph(3'h5, 3'h7, 1'b1, 5'h1f);
        check(17'({pattern_active_out, pattern_row_out}), 17'h2b);
        glyph(3'h5, 3'h6, 1'b1, 5'h1f);
        check(17'({pattern_active_out, pattern_row_out}), 17'h2d);
        glyph(3'h6, 3'h0, 1'b0, 5'h1f);
        check(17'({pattern_active_out, pattern_row_out}), 17'h0);
        put(1'b0, 8'hff);
        put(1'b1, 8'h15);
        put(1'b1, 8'h0c);
        glyph(3'h0, 3'h0, 1'b0, 5'h1f);
        check(17'({pattern_active_out, pattern_row_out}), 17'h2c);
        check(17'({bank_select_bit_out, symbol_row_out}), 17'h35);
        for (i = 0; i < 2; i++) begin
            put(1'b0, 8'he0);
            put(1'b1, i ? 8'hd5 : 8'h95);
            glyph(3'h0, 3'h0, 1'b0, 5'h00);
            watch(1'b1, 10'h015, i ? 10'h000 : 10'h00a);
        end
        put(1'b0, 8'h32);
        glyph(3'h5, 3'h0, 1'b0, 5'h00);
        check(17'({pattern_active_out, pattern_row_out}), 17'h0);
        put(1'b0, 8'h20);
        put(1'b0, 8'h80);
        repeat (4) put(1'b1, 8'h00);
        put(1'b0, 8'h30);
        repeat (20) @(negedge mclk_in);
        check(17'({oscillator_on_out, static_icon_out}), 17'h0);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(negedge mclk_in);
        check({oscillator_on_out, bank_select_bit_out, lcd_drive_voltage_out, static_icon_out}, 17'h0);
        report_and_stop();
    end
endmodule : lcd_pattern_icon_ram_test

bind lcd_pattern_icon_ram lcd_pattern_icon_ram_monitor u_lcd_pattern_icon_ram_monitor (.mclk_in,
    .rst_in, .write_n_in, .pattern_code_in, .symbol_index_in, .pattern_row_out,
    .pattern_active_out, .symbol_row_out, .static_icon_out, .lcd_drive_voltage_out,
    .bank_select_bit_out, .oscillator_on_out);
`default_nettype wire
